// ==== rtl/bsc_defs.svh ====
`ifndef BSC_DEFS_SVH
`define BSC_DEFS_SVH

// word selector codes carried in the low three bits of every serial word
`define SEL_LSB 0
`define SEL_MSB 2
`define WORD_RX_DIVIDE 3'h0
`define WORD_TX_DIVIDE 3'h1
`define WORD_RX_REFERENCE 3'h2
`define WORD_TX_REFERENCE 3'h3
`define WORD_SYNTH_SETUP 3'h4
`define WORD_TX_MODE_GAIN 3'h5
`define WORD_RX_MODE_POWER 3'h6
`define WORD_CUTOFF 3'h7
`define WORD_RESET 24'h000000

// divider words: main counter and swallow counter
`define M_MSB 20
`define M_LSB 10
`define A_MSB 9
`define A_LSB 3
// reference words
`define REF_MSB 17
`define REF_LSB 3
`define RX_LOCK_INVERT_BIT 18
`define TX_LOCK_INVERT_BIT 19
`define TX_POLARITY_BIT 18
// synthesiser setup word
`define RX_POLARITY_BIT 20
`define TX_PRESCALER_MSB 17
`define TX_PRESCALER_LSB 15
`define RX_PRESCALER_MSB 14
`define RX_PRESCALER_LSB 12
`define RX_TRISTATE_BIT 11
`define TX_TRISTATE_BIT 10
`define TX_PUMP_MSB 9
`define TX_PUMP_LSB 8
`define RX_PUMP_MSB 7
`define RX_PUMP_LSB 6
`define LOCK_SOURCE_BIT 5
// transmit mode and gain word
`define TX_GAIN_MSB 13
`define TX_GAIN_LSB 11
`define CAL_START_BIT 10
`define TX_MODE_MSB 9
`define TX_MODE_LSB 8
`define CAL_RESULT_MSB 6
`define CAL_RESULT_LSB 3
// receive mode and power word
`define POWER_MODE_MSB 17
`define POWER_MODE_LSB 15
`define ATTEN_MANUAL_BIT 12
`define RX_MODE_BIT 11
`define RX_SETTING_MSB 9
`define RX_SETTING_LSB 6
// cutoff word
`define CUTOFF_MSB 23
`define CUTOFF_LSB 16

// pump currents in microamps
`define PUMP_UA_CODE0 9'h1f0
`define PUMP_UA_CODE1 9'h0b0
`define PUMP_UA_CODE2 9'h060
`define PUMP_UA_CODE3 9'h010

// timing
`define CLOCK_PERIOD_PS 5000
`define CAL_TIME_NS 600000
`define CAL_CYCLES (`CAL_TIME_NS * 1000 / `CLOCK_PERIOD_PS)
`define LOCK_COUNT 4

`endif

// ==== rtl/bsc_pkg.sv ====
package bsc_pkg;
	typedef enum logic [2:0] {
		PWR_DEEP_SLEEP = 3'b000,
		PWR_SLEEP = 3'b100,
		PWR_TX = 3'b010,
		PWR_RX = 3'b110,
		PWR_DUPLEX = 3'b001,
		PWR_ALT = 3'b101,
		PWR_RSSI_ON = 3'b011,
		PWR_RSSI_OFF = 3'b111
	} power_mode_e;

	typedef enum logic [0:0] {
		CAL_IDLE = 1'b0,
		CAL_RUN = 1'b1
	} cal_state_e;

	typedef logic [23:0] word_t;
endpackage

// ==== rtl/serial_shift_in.sv ====
`timescale 1ns/1ps
module serial_shift_in #(
	parameter int WIDTH = 24
) (
	input wire logic clock_in,
	input wire logic reset_n_in,
	input wire logic sclk_in,
	input wire logic sdata_in,
	input wire logic latch_in,
	output logic [WIDTH-1:0] word_out,
	output logic valid_out
);
	initial begin
		if (WIDTH < 4) $error("serial word too short");
	end

	logic sclk_q, latch_q;
	logic [WIDTH-1:0] shift_q, shift_d, word_d;
	logic valid_d;

	// msb first on serial clock rise; latch rise hands over bits shifted so far
	always_comb begin
		shift_d = shift_q;
		word_d = word_out;
		valid_d = 1'b0;
		if (sclk_in && !sclk_q) begin
			shift_d = {shift_q[WIDTH-2:0], sdata_in}; // see R26
		end
		if (latch_in && !latch_q) begin
			word_d = shift_q; // see R23
			valid_d = 1'b1;
		end
	end

	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			sclk_q <= 1'b0;
			latch_q <= 1'b0;
			shift_q <= '0;
			word_out <= '0;
			valid_out <= 1'b0;
		end else begin
			sclk_q <= sclk_in;
			latch_q <= latch_in;
			shift_q <= shift_d;
			word_out <= word_d;
			valid_out <= valid_d;
		end
	end
endmodule

// ==== rtl/synth_divider.sv ====
`timescale 1ns/1ps
module synth_divider #(
	parameter int M_WIDTH = 11,
	parameter int A_WIDTH = 7,
	parameter int REF_WIDTH = 15,
	parameter int LOCK_COUNT = 4
) (
	input wire logic clock_in,
	input wire logic reset_n_in,
	input wire logic vco_in,
	input wire logic [M_WIDTH-1:0] m_in,
	input wire logic [A_WIDTH-1:0] a_in,
	input wire logic [2:0] prescaler_select_in,
	input wire logic [REF_WIDTH-1:0] ref_divide_in,
	input wire logic polarity_in,
	input wire logic tristate_in,
	output logic pump_up_out,
	output logic pump_down_out,
	output logic pump_oe_out,
	output logic lock_out
);
	localparam int TW = M_WIDTH + 8;
	initial begin
		if (A_WIDTH > 7 || LOCK_COUNT < 1 || LOCK_COUNT > 15) $error("bad divider sizing");
	end

	logic vco_q, up_q, dn_q, up_d, dn_d, fb_pulse, ref_pulse;
	logic up_o, dn_o, oe_o, lock_o;
	logic [2:0] shift;
	logic [TW-1:0] ratio, fb_cnt_q, fb_cnt_d;
	logic [REF_WIDTH-1:0] ref_cnt_q, ref_cnt_d;
	logic [1:0] fb_seen_q, fb_seen_d;
	logic [3:0] lock_cnt_q, lock_cnt_d;

	// feedback counts vco edges to M*N+A, the same total as a swallow/main pair
	always_comb begin
		shift = prescaler_select_in[2] ? (3'h4 + {1'b0, prescaler_select_in[1:0]}) :
			3'h3; // see R13
		ratio = TW'({8'h00, m_in} << shift) + TW'(a_in); // see R09
		fb_cnt_d = fb_cnt_q;
		fb_pulse = 1'b0;
		if (vco_in && !vco_q) begin
			if ({1'b0, fb_cnt_q} + (TW+1)'(1) >= {1'b0, ratio}) begin
				fb_cnt_d = '0;
				fb_pulse = 1'b1;
			end else begin
				fb_cnt_d = fb_cnt_q + TW'(1);
			end
		end
		ref_pulse = 1'b0;
		ref_cnt_d = ref_cnt_q + REF_WIDTH'(1);
		if ({1'b0, ref_cnt_q} + (REF_WIDTH+1)'(1) >= {1'b0, ref_divide_in}) begin
			ref_cnt_d = '0;
			ref_pulse = 1'b1; // see R12
		end
		// phase detector: both flags set clears both
		up_d = up_q | ref_pulse;
		dn_d = dn_q | fb_pulse;
		if (up_d && dn_d) begin
			up_d = 1'b0;
			dn_d = 1'b0;
		end
		// lock means one feedback pulse per reference period, several periods running
		fb_seen_d = fb_seen_q;
		if (fb_pulse && fb_seen_q != 2'h3) fb_seen_d = fb_seen_q + 2'h1;
		lock_cnt_d = lock_cnt_q;
		if (ref_pulse) begin
			fb_seen_d = 2'h0;
			if (fb_seen_q + {1'b0, fb_pulse} == 2'h1) begin
				if (lock_cnt_q != 4'(LOCK_COUNT)) lock_cnt_d = lock_cnt_q + 4'h1;
			end else begin
				lock_cnt_d = 4'h0;
			end
		end
		lock_o = (lock_cnt_d == 4'(LOCK_COUNT)); // see R16
		// polarity swaps the pump directions; tristate releases the pump
		oe_o = !tristate_in; // see R15
		up_o = oe_o && (polarity_in ? dn_d : up_d);
		dn_o = oe_o && (polarity_in ? up_d : dn_d);
	end

	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			vco_q <= 1'b0;
			up_q <= 1'b0;
			dn_q <= 1'b0;
			fb_cnt_q <= '0;
			ref_cnt_q <= '0;
			fb_seen_q <= 2'h0;
			lock_cnt_q <= 4'h0;
			pump_up_out <= 1'b0;
			pump_down_out <= 1'b0;
			pump_oe_out <= 1'b0;
			lock_out <= 1'b0;
		end else begin
			vco_q <= vco_in;
			up_q <= up_d;
			dn_q <= dn_d;
			fb_cnt_q <= fb_cnt_d;
			ref_cnt_q <= ref_cnt_d;
			fb_seen_q <= fb_seen_d;
			lock_cnt_q <= lock_cnt_d;
			pump_up_out <= up_o;
			pump_down_out <= dn_o;
			pump_oe_out <= oe_o;
			lock_out <= lock_o;
		end
	end
endmodule

// ==== rtl/baseband_serial_control_bank.sv ====
`timescale 1ns/1ps
`include "bsc_defs.svh"

// Summary of operation
// R01: receive mode bit picks baseband or discriminator
// R02: receive setting gives gain and bandwidth
// R03: manual select lets bit 3 force attenuator
// R04: transmit mode selects quadrature or direct FM
// R05: calibrate start runs, stores result, self clears
// R06: controller loads cutoff value before calibrating
// R07: overwritten result needs a fresh calibration
// R08: transmit gain code decodes zero to twelve dB
// R09: synthesiser divides vco by M times N plus A
// R10: swallow count stays below prescaler modulus
// R11: divider words supply M and A fields
// R12: fifteen-bit reference divider per synthesiser
// R13: prescaler select picks modulus eight to 128
// R14: pump current codes give four currents
// R15: polarity inverts pump, tristate releases it
// R16: lock high when locked, invert bits flip
// R17: lock source picks receive or transmit lock
// R18: combined lock is external AND selected lock
// R19: power mode field decodes eight modes
// R20: alternating mode follows the power assert pin
// R21: power commands take effect through the pin
// R22: signal strength on precedes receive modes
// R23: twenty-four bits then latch load one word
// R24: latch stays low except after last bit
// R25: low three bits select the target word
// R26: data sampled on clock rise, msb first
module baseband_serial_control_bank #(
	parameter int CAL_CYCLES = `CAL_CYCLES,
	parameter int LOCK_COUNT = `LOCK_COUNT
) (
	input wire logic CLOCK_IN,
	input wire logic RESET_N_IN,
	input wire logic SERIAL_CLOCK_IN,
	input wire logic SERIAL_DATA_IN,
	input wire logic SERIAL_LATCH_IN,
	input wire logic POWER_ASSERT_PIN_IN,
	input wire logic EXTERNAL_LOCK_INPUT_IN,
	input wire logic RX_VCO_IN,
	input wire logic TX_VCO_IN,
	input wire logic ATTENUATOR_AUTO_IN,
	input wire logic [3:0] CAL_CODE_IN,
	output logic COMBINED_LOCK_OUTPUT_OUT,
	output logic RX_FM_MODE_OUT,
	output logic BASEBAND_RX_POWER_OUT,
	output logic DISCRIMINATOR_POWER_OUT,
	output logic [1:0] RX_GAIN_CODE_OUT,
	output logic RX_NARROW_BAND_OUT,
	output logic ATTENUATOR_ENABLE_OUT,
	output logic TX_FM_MODE_OUT,
	output logic [3:0] TX_GAIN_DB_OUT,
	output logic CAL_RUNNING_OUT,
	output logic [7:0] CAL_CUTOFF_OUT,
	output logic RX_POWER_OUT,
	output logic TX_POWER_OUT,
	output logic REFERENCE_POWER_OUT,
	output logic RSSI_POWER_OUT,
	output logic [8:0] RX_PUMP_CURRENT_UA_OUT,
	output logic [8:0] TX_PUMP_CURRENT_UA_OUT,
	output logic RX_PUMP_UP_OUT,
	output logic RX_PUMP_DOWN_OUT,
	output logic RX_PUMP_OE_OUT,
	output logic TX_PUMP_UP_OUT,
	output logic TX_PUMP_DOWN_OUT,
	output logic TX_PUMP_OE_OUT
);
	localparam int CW = $clog2(CAL_CYCLES);
	initial begin
		if (CAL_CYCLES < 2) $error("calibration time too short");
	end

	bsc_pkg::word_t word_q [8];
	bsc_pkg::word_t word_d [8];
	bsc_pkg::word_t shift_word;
	logic word_valid, rx_lock, tx_lock;
	logic [2:0] sel;

	// serial front end: msb-first shift, latch edge delivers one word
	serial_shift_in #(.WIDTH(24)) u_shift (
		.clock_in(CLOCK_IN),
		.reset_n_in(RESET_N_IN),
		.sclk_in(SERIAL_CLOCK_IN),
		.sdata_in(SERIAL_DATA_IN),
		.latch_in(SERIAL_LATCH_IN),
		.word_out(shift_word),
		.valid_out(word_valid)
	);

	assign sel = shift_word[`SEL_MSB:`SEL_LSB]; // see R25

	// calibration sequencer
	bsc_pkg::cal_state_e cal_state_q, cal_state_d;
	logic [CW-1:0] cal_cnt_q, cal_cnt_d;
	logic cal_done, cal_start;

	always_comb begin
		cal_state_d = cal_state_q;
		cal_cnt_d = cal_cnt_q;
		cal_done = 1'b0;
		cal_start = word_valid && sel == `WORD_TX_MODE_GAIN && shift_word[`CAL_START_BIT];
		case (cal_state_q)
			bsc_pkg::CAL_IDLE: begin
				if (cal_start) begin
					cal_state_d = bsc_pkg::CAL_RUN; // see R05
					cal_cnt_d = '0;
				end
			end
			bsc_pkg::CAL_RUN: begin
				if (cal_start) begin
					cal_cnt_d = '0; // a fresh start restarts the timer
				end else if (cal_cnt_q == CW'(CAL_CYCLES - 1)) begin
					cal_state_d = bsc_pkg::CAL_IDLE;
					cal_done = 1'b1;
				end else begin
					cal_cnt_d = cal_cnt_q + CW'(1);
				end
			end
			default: cal_state_d = bsc_pkg::CAL_IDLE;
		endcase
	end

	always_ff @(posedge CLOCK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			cal_state_q <= bsc_pkg::CAL_IDLE;
			cal_cnt_q <= '0;
		end else begin
			cal_state_q <= cal_state_d;
			cal_cnt_q <= cal_cnt_d;
		end
	end

	// word bank: a serial write in the same cycle beats the calibration update,
	// so nothing the controller loaded is silently lost
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			word_d[i] = word_q[i];
		end
		if (cal_done) begin
			word_d[`WORD_TX_MODE_GAIN][`CAL_RESULT_MSB:`CAL_RESULT_LSB] = CAL_CODE_IN; // see R05
			word_d[`WORD_TX_MODE_GAIN][`CAL_START_BIT] = 1'b0;
		end
		if (word_valid) begin
			word_d[sel] = shift_word; // see R23
		end
	end

	always_ff @(posedge CLOCK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			for (int i = 0; i < 8; i++) begin
				word_q[i] <= `WORD_RESET;
			end
		end else begin
			for (int i = 0; i < 8; i++) begin
				word_q[i] <= word_d[i];
			end
		end
	end

	// power commit: pending code applies on the assert pin's rise, the
	// alternating code applies while the pin is low
	bsc_pkg::power_mode_e pending_mode, power_mode_q, power_mode_d;
	logic pca_q, rssi_en_q, rssi_en_d;

	always_comb begin
		pending_mode = bsc_pkg::power_mode_e'(word_q[`WORD_RX_MODE_POWER][`POWER_MODE_MSB:`POWER_MODE_LSB]);
		power_mode_d = power_mode_q;
		rssi_en_d = rssi_en_q;
		if (pending_mode == bsc_pkg::PWR_ALT) begin
			if (!POWER_ASSERT_PIN_IN) power_mode_d = bsc_pkg::PWR_ALT; // see R21
		end else if (POWER_ASSERT_PIN_IN && !pca_q) begin
			case (pending_mode)
				bsc_pkg::PWR_RSSI_ON: rssi_en_d = 1'b1; // see R22
				bsc_pkg::PWR_RSSI_OFF: rssi_en_d = 1'b0;
				default: power_mode_d = pending_mode; // see R21
			endcase
		end
	end

	always_ff @(posedge CLOCK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			pca_q <= 1'b1; // pin idles high, so no false rise follows reset
			power_mode_q <= bsc_pkg::PWR_DEEP_SLEEP;
			rssi_en_q <= 1'b0;
		end else begin
			pca_q <= POWER_ASSERT_PIN_IN;
			power_mode_q <= power_mode_d;
			rssi_en_q <= rssi_en_d;
		end
	end

	// the two synthesisers share one design
	synth_divider #(.LOCK_COUNT(LOCK_COUNT)) u_rx_synth (
		.clock_in(CLOCK_IN),
		.reset_n_in(RESET_N_IN),
		.vco_in(RX_VCO_IN),
		.m_in(word_q[`WORD_RX_DIVIDE][`M_MSB:`M_LSB]), // see R11
		.a_in(word_q[`WORD_RX_DIVIDE][`A_MSB:`A_LSB]),
		.prescaler_select_in(word_q[`WORD_SYNTH_SETUP][`RX_PRESCALER_MSB:`RX_PRESCALER_LSB]),
		.ref_divide_in(word_q[`WORD_RX_REFERENCE][`REF_MSB:`REF_LSB]),
		.polarity_in(word_q[`WORD_SYNTH_SETUP][`RX_POLARITY_BIT]),
		.tristate_in(word_q[`WORD_SYNTH_SETUP][`RX_TRISTATE_BIT]),
		.pump_up_out(RX_PUMP_UP_OUT),
		.pump_down_out(RX_PUMP_DOWN_OUT),
		.pump_oe_out(RX_PUMP_OE_OUT),
		.lock_out(rx_lock)
	);

	synth_divider #(.LOCK_COUNT(LOCK_COUNT)) u_tx_synth (
		.clock_in(CLOCK_IN),
		.reset_n_in(RESET_N_IN),
		.vco_in(TX_VCO_IN),
		.m_in(word_q[`WORD_TX_DIVIDE][`M_MSB:`M_LSB]), // see R11
		.a_in(word_q[`WORD_TX_DIVIDE][`A_MSB:`A_LSB]),
		.prescaler_select_in(word_q[`WORD_SYNTH_SETUP][`TX_PRESCALER_MSB:`TX_PRESCALER_LSB]),
		.ref_divide_in(word_q[`WORD_TX_REFERENCE][`REF_MSB:`REF_LSB]),
		.polarity_in(word_q[`WORD_TX_REFERENCE][`TX_POLARITY_BIT]),
		.tristate_in(word_q[`WORD_SYNTH_SETUP][`TX_TRISTATE_BIT]),
		.pump_up_out(TX_PUMP_UP_OUT),
		.pump_down_out(TX_PUMP_DOWN_OUT),
		.pump_oe_out(TX_PUMP_OE_OUT),
		.lock_out(tx_lock)
	);

	function automatic logic [8:0] pump_ua(input logic [1:0] code);
		case (code)
			2'h0: pump_ua = `PUMP_UA_CODE0;
			2'h1: pump_ua = `PUMP_UA_CODE1;
			2'h2: pump_ua = `PUMP_UA_CODE2;
			default: pump_ua = `PUMP_UA_CODE3;
		endcase
	endfunction

	// decoded control outputs, all registered
	bsc_pkg::word_t w5, w6, w7;
	logic sel_lock, rx_on, tx_on, ref_on;
	logic [3:0] gain_db;

	always_comb begin
		w5 = word_q[`WORD_SYNTH_SETUP];
		w6 = word_q[`WORD_TX_MODE_GAIN];
		w7 = word_q[`WORD_RX_MODE_POWER];
		sel_lock = w5[`LOCK_SOURCE_BIT] ? // see R17
			(tx_lock ^ word_q[`WORD_RX_REFERENCE][`TX_LOCK_INVERT_BIT]) :
			(rx_lock ^ word_q[`WORD_RX_REFERENCE][`RX_LOCK_INVERT_BIT]); // see R16
		case (w6[`TX_GAIN_MSB:`TX_GAIN_LSB])
			3'b000: gain_db = 4'h3;
			3'b010: gain_db = 4'h6;
			3'b100: gain_db = 4'h9;
			3'b110: gain_db = 4'hc;
			default: gain_db = 4'h0; // low bit set means 0 dB, see R08
		endcase
		rx_on = 1'b0;
		tx_on = 1'b0;
		ref_on = 1'b1;
		case (power_mode_q) // see R19
			bsc_pkg::PWR_DEEP_SLEEP: ref_on = 1'b0;
			bsc_pkg::PWR_TX: tx_on = 1'b1;
			bsc_pkg::PWR_RX: rx_on = 1'b1;
			bsc_pkg::PWR_DUPLEX: begin
				rx_on = 1'b1;
				tx_on = 1'b1;
			end
			bsc_pkg::PWR_ALT: begin
				rx_on = !POWER_ASSERT_PIN_IN; // see R20
				tx_on = POWER_ASSERT_PIN_IN;
			end
			default: ref_on = 1'b1;
		endcase
	end

	always_ff @(posedge CLOCK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			COMBINED_LOCK_OUTPUT_OUT <= 1'b0;
			RX_FM_MODE_OUT <= 1'b0;
			BASEBAND_RX_POWER_OUT <= 1'b0;
			DISCRIMINATOR_POWER_OUT <= 1'b0;
			RX_GAIN_CODE_OUT <= 2'h0;
			RX_NARROW_BAND_OUT <= 1'b0;
			ATTENUATOR_ENABLE_OUT <= 1'b0;
			TX_FM_MODE_OUT <= 1'b0;
			TX_GAIN_DB_OUT <= 4'h0;
			CAL_RUNNING_OUT <= 1'b0;
			CAL_CUTOFF_OUT <= 8'h00;
			RX_POWER_OUT <= 1'b0;
			TX_POWER_OUT <= 1'b0;
			REFERENCE_POWER_OUT <= 1'b0;
			RSSI_POWER_OUT <= 1'b0;
			RX_PUMP_CURRENT_UA_OUT <= 9'h000;
			TX_PUMP_CURRENT_UA_OUT <= 9'h000;
		end else begin
			COMBINED_LOCK_OUTPUT_OUT <= EXTERNAL_LOCK_INPUT_IN && sel_lock; // see R18
			RX_FM_MODE_OUT <= w7[`RX_MODE_BIT]; // see R01
			BASEBAND_RX_POWER_OUT <= rx_on && !w7[`RX_MODE_BIT]; // see R01
			DISCRIMINATOR_POWER_OUT <= rx_on && w7[`RX_MODE_BIT];
			RX_GAIN_CODE_OUT <= w7[`RX_SETTING_LSB+1:`RX_SETTING_LSB]; // see R02
			RX_NARROW_BAND_OUT <= w7[`RX_SETTING_LSB+2]; // see R02
			// manual: setting bit 3 at 0 enables; else the level comparator decides
			ATTENUATOR_ENABLE_OUT <= w7[`ATTEN_MANUAL_BIT] ?
				!w7[`RX_SETTING_MSB] : ATTENUATOR_AUTO_IN; // see R03
			TX_FM_MODE_OUT <= w6[`TX_MODE_MSB] && !w6[`TX_MODE_LSB]; // see R04
			TX_GAIN_DB_OUT <= gain_db; // see R08
			CAL_RUNNING_OUT <= cal_state_d == bsc_pkg::CAL_RUN;
			CAL_CUTOFF_OUT <= word_q[`WORD_CUTOFF][`CUTOFF_MSB:`CUTOFF_LSB]; // see R06
			RX_POWER_OUT <= rx_on;
			TX_POWER_OUT <= tx_on;
			REFERENCE_POWER_OUT <= ref_on;
			RSSI_POWER_OUT <= rx_on && rssi_en_q; // see R22
			RX_PUMP_CURRENT_UA_OUT <= pump_ua(w5[`RX_PUMP_MSB:`RX_PUMP_LSB]); // see R14
			TX_PUMP_CURRENT_UA_OUT <= pump_ua(w5[`TX_PUMP_MSB:`TX_PUMP_LSB]);
		end
	end

	default clocking cb @(posedge CLOCK_IN);
	endclocking
	default disable iff (!RESET_N_IN);

	chk_word_load_select: assert property ( // see R25
		word_valid |=> word_q[$past(sel)] == $past(shift_word))
		else $error("latched word not stored at selected index");
	chk_rx_path_select: assert property ( // see R01
		##1 RX_FM_MODE_OUT == $past(w7[`RX_MODE_BIT]) && !(BASEBAND_RX_POWER_OUT && DISCRIMINATOR_POWER_OUT))
		else $error("receive path select wrong");
	chk_attenuator_manual: assert property ( // see R03
		w7[`ATTEN_MANUAL_BIT] |=> ATTENUATOR_ENABLE_OUT == !$past(w7[`RX_SETTING_MSB]))
		else $error("manual attenuator not forced");
	chk_tx_gain_zero: assert property ( // see R08
		w6[`TX_GAIN_LSB] |=> TX_GAIN_DB_OUT == 4'h0)
		else $error("gain not 0 dB with low bit set");
	chk_cal_clears_start: assert property ( // see R05
		cal_done && !word_valid |=> !w6[`CAL_START_BIT] && w6[6:3] == $past(CAL_CODE_IN))
		else $error("calibration end did not store result");
	chk_cal_timer_runs: assert property ( // see R05
		cal_start ##1 (!cal_start)[*3] |-> CAL_RUNNING_OUT && cal_cnt_q == CW'(2))
		else $error("calibration timer not running");
	chk_lock_gate: assert property ( // see R18
		!EXTERNAL_LOCK_INPUT_IN |=> !COMBINED_LOCK_OUTPUT_OUT)
		else $error("combined lock high without external lock");
	chk_alt_follows_pin: assert property ( // see R20
		power_mode_q == bsc_pkg::PWR_ALT |=> RX_POWER_OUT == !$past(POWER_ASSERT_PIN_IN)
			&& TX_POWER_OUT == $past(POWER_ASSERT_PIN_IN))
		else $error("alternating mode not following pin");
	chk_pin_commit: assert property ( // see R21
		$rose(POWER_ASSERT_PIN_IN) && pending_mode == bsc_pkg::PWR_DUPLEX |=>
			power_mode_q == bsc_pkg::PWR_DUPLEX)
		else $error("power command not committed on pin rise");
	chk_pump_current: assert property ( // see R14
		w5[`RX_PUMP_MSB:`RX_PUMP_LSB] == 2'h0 |=> RX_PUMP_CURRENT_UA_OUT == `PUMP_UA_CODE0)
		else $error("receive pump current decode wrong");

	cov_cal_done: cover property (cal_done);
	cov_alt_toggle: cover property (power_mode_q == bsc_pkg::PWR_ALT ##1 $rose(POWER_ASSERT_PIN_IN));
	cov_all_locked: cover property ($rose(COMBINED_LOCK_OUTPUT_OUT));
endmodule

// ==== sim/bb_controller.sv ====
`timescale 1ns/1ps
// stands in for the baseband controller on the serial bus and power pin
module bb_controller (
	input wire logic clock_in,
	output logic sclk_out,
	output logic sdata_out,
	output logic latch_out,
	output logic pin_out
);
	// serial clock stands low outside frames, latch idles low
	initial begin
		sclk_out = 1'b0;
		sdata_out = 1'b0;
		latch_out = 1'b0;
		pin_out = 1'b1;
	end

	// every serial level is held two clocks so the sampler sees each edge
	task automatic hold2();
		repeat (2) @(posedge clock_in);
	endtask

	// msb first, data steady across the clock rise, then one latch pulse
	task automatic send_word(input bsc_pkg::word_t w);
		@(posedge clock_in);
		for (int i = 23; i >= 0; i--) begin
			sdata_out <= w[i];
			sclk_out <= 1'b0;
			hold2();
			sclk_out <= 1'b1;
			hold2();
		end
		sclk_out <= 1'b0;
		sdata_out <= ~w[0]; // stale data is not left looking valid
		hold2();
		latch_out <= 1'b1; // single pulse after the last bit only
		hold2();
		latch_out <= 1'b0;
		hold2();
	endtask

	// ordinary power commands load with the pin high, then a pin rise commits
	task automatic power_cmd(input bsc_pkg::word_t w);
		@(posedge clock_in);
		pin_out <= 1'b1;
		send_word(w);
		pin_out <= 1'b0;
		hold2();
		pin_out <= 1'b1;
		hold2();
	endtask

	// alternating mode loads with the pin low
	task automatic alt_cmd(input bsc_pkg::word_t w);
		@(posedge clock_in);
		pin_out <= 1'b0;
		send_word(w);
	endtask

	task automatic set_pin(input logic v);
		@(posedge clock_in);
		pin_out <= v;
	endtask
endmodule

// ==== sim/baseband_serial_control_bank_tb.sv ====
`timescale 1ns/1ps
`include "bsc_defs.svh"
module baseband_serial_control_bank_tb;
	logic clk, rst_n, ext_lock, atten_auto, sclk, sdata, latch, pin;
	logic comb, rx_fm, bb_pwr, disc_pwr, narrow, att_en, tx_fm, cal_run;
	logic rx_pwr, tx_pwr, ref_pwr, rssi_pwr, rx_oe, tx_oe;
	logic [1:0] rx_gain;
	logic [3:0] tx_db;
	logic [3:0] cal_code;
	logic [7:0] cutoff;
	logic [8:0] rx_ua, tx_ua;
	int err_total, check_count, cal_cnt;
	logic [8:0] ua [4] = '{9'h1f0, 9'h0b0, 9'h060, 9'h010};
	logic [5:0] rcfg [3] = '{6'b111101, 6'b100010, 6'b001000};
	logic [2:0] gcode [5] = '{3'b001, 3'b000, 3'b010, 3'b100, 3'b110};
	logic [3:0] gdb [5] = '{4'h0, 4'h3, 4'h6, 4'h9, 4'hc};
	logic [2:0] pcode [5] = '{3'b100, 3'b010, 3'b110, 3'b001, 3'b000};
	logic [2:0] pexp [5] = '{3'b001, 3'b011, 3'b101, 3'b111, 3'b000};

	bb_controller u_ctl (.clock_in(clk), .sclk_out(sclk), .sdata_out(sdata),
		.latch_out(latch), .pin_out(pin));

	// short calibration so the run stays brief
	baseband_serial_control_bank #(.CAL_CYCLES(20), .LOCK_COUNT(4)) dut (
		.CLOCK_IN(clk), .RESET_N_IN(rst_n), .SERIAL_CLOCK_IN(sclk),
		.SERIAL_DATA_IN(sdata), .SERIAL_LATCH_IN(latch), .POWER_ASSERT_PIN_IN(pin),
		.EXTERNAL_LOCK_INPUT_IN(ext_lock), .RX_VCO_IN(1'b0), .TX_VCO_IN(1'b0),
		.ATTENUATOR_AUTO_IN(atten_auto), .CAL_CODE_IN(cal_code),
		.COMBINED_LOCK_OUTPUT_OUT(comb), .RX_FM_MODE_OUT(rx_fm),
		.BASEBAND_RX_POWER_OUT(bb_pwr), .DISCRIMINATOR_POWER_OUT(disc_pwr),
		.RX_GAIN_CODE_OUT(rx_gain), .RX_NARROW_BAND_OUT(narrow),
		.ATTENUATOR_ENABLE_OUT(att_en), .TX_FM_MODE_OUT(tx_fm), .TX_GAIN_DB_OUT(tx_db),
		.CAL_RUNNING_OUT(cal_run), .CAL_CUTOFF_OUT(cutoff), .RX_POWER_OUT(rx_pwr),
		.TX_POWER_OUT(tx_pwr), .REFERENCE_POWER_OUT(ref_pwr), .RSSI_POWER_OUT(rssi_pwr),
		.RX_PUMP_CURRENT_UA_OUT(rx_ua), .TX_PUMP_CURRENT_UA_OUT(tx_ua),
		.RX_PUMP_UP_OUT(), .RX_PUMP_DOWN_OUT(), .RX_PUMP_OE_OUT(rx_oe),
		.TX_PUMP_UP_OUT(), .TX_PUMP_DOWN_OUT(), .TX_PUMP_OE_OUT(tx_oe));

	// 200 MHz system clock
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// counts cycles in which a calibration is seen running
	always @(posedge clk) begin
		if (cal_run === 1'b1) cal_cnt <= cal_cnt + 1;
	end

	function automatic bsc_pkg::word_t mk(input logic [2:0] s, input bsc_pkg::word_t f);
		return {f[23:3], s};
	endfunction

	function automatic bsc_pkg::word_t pw(input logic [2:0] c);
		return {6'h00, c, 12'h000, `WORD_RX_MODE_POWER};
	endfunction

	task automatic settle(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic chk(input string name, input logic [8:0] exp, input logic [8:0] got);
		check_count++;
		if (got !== exp) begin
			err_total++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// a hang is cut short long after the sequence should have ended
	initial begin
		repeat (40000) @(posedge clk);
		err_total++;
		end_of_test();
	end

	// main sequence: reset, then word by word through the control fields
	initial begin
		rst_n = 1'b0;
		ext_lock = 1'b0;
		atten_auto = 1'b1;
		cal_code = 4'h0;
		err_total = 0;
		check_count = 0;
		cal_cnt = 0;
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		settle(2);
		chk("ref_power", 9'h000, ref_pwr);
		chk("rx_pump_ua", ua[0], rx_ua);
		for (int i = 0; i < 4; i++) begin
			u_ctl.send_word(mk(`WORD_SYNTH_SETUP, {12'h000, i[0], i[1], 2'(3 - i), 2'(i), 6'h00}));
			settle(2);
			chk("rx_pump_ua", ua[i], rx_ua);
			chk("tx_pump_ua", ua[3 - i], tx_ua);
			chk("rx_pump_oe", {8'h00, ~i[0]}, rx_oe);
			chk("tx_pump_oe", {8'h00, ~i[1]}, tx_oe);
		end
		for (int j = 0; j < 3; j++) begin
			u_ctl.send_word(mk(`WORD_RX_MODE_POWER, {11'h000, rcfg[j][5:4], 1'b0, rcfg[j][3:0], 6'h00}));
			settle(2);
			chk("rx_fm", rcfg[j][4], rx_fm);
			chk("narrow", rcfg[j][2], narrow);
			chk("rx_gain", rcfg[j][1:0], rx_gain);
			chk("atten", rcfg[j][5] ? !rcfg[j][3] : atten_auto, att_en);
		end
		@(posedge clk);
		atten_auto <= 1'b0;
		settle(3);
		chk("atten", 9'h000, att_en);
		for (int k = 0; k < 5; k++) begin
			u_ctl.send_word(mk(`WORD_TX_MODE_GAIN, {10'h000, gcode[k], 1'b0, k[0], 9'h000}));
			settle(2);
			chk("tx_gain_db", gdb[k], tx_db);
			chk("tx_fm", k[0], tx_fm);
		end
		u_ctl.send_word(mk(`WORD_CUTOFF, 24'h0c0000));
		cal_code <= 4'h5;
		settle(2);
		chk("cutoff", 9'h00c, cutoff);
		// swallow count 5 stays below the 8/9 modulus still selected
		u_ctl.send_word(mk(`WORD_RX_DIVIDE, {3'h0, 11'h010, 7'h05, 3'h0}));
		settle(2);
		chk("rx_pump_oe", 9'h000, rx_oe);
		cal_cnt = 0;
		u_ctl.send_word(mk(`WORD_TX_MODE_GAIN, 24'h000400));
		for (int w = 0; w < 60 && cal_run !== 1'b0; w++) settle(1);
		settle(1);
		chk("cal_cycles", 9'd20, 9'(cal_cnt));
		u_ctl.power_cmd(pw(3'b011));
		for (int p = 0; p < 5; p++) begin
			u_ctl.power_cmd(pw(pcode[p]));
			settle(2);
			chk("rx_tx_ref", pexp[p], {rx_pwr, tx_pwr, ref_pwr});
			chk("baseband_rx", pexp[p][2], bb_pwr);
			chk("discriminator", 9'h000, disc_pwr);
			chk("rssi_power", pexp[p][2], rssi_pwr);
		end
		u_ctl.alt_cmd(pw(3'b101));
		settle(3);
		chk("alt_low", 9'h002, {rx_pwr, tx_pwr});
		u_ctl.set_pin(1'b1);
		settle(3);
		chk("alt_high", 9'h001, {rx_pwr, tx_pwr});
		u_ctl.send_word(mk(`WORD_RX_REFERENCE, 24'h040000));
		u_ctl.send_word(mk(`WORD_SYNTH_SETUP, 24'h000000));
		ext_lock <= 1'b1;
		settle(3);
		chk("comb_lock", 9'h001, comb);
		@(posedge clk);
		ext_lock <= 1'b0;
		settle(3);
		chk("comb_lock", 9'h000, comb);
		@(posedge clk);
		ext_lock <= 1'b1;
		u_ctl.send_word(mk(`WORD_SYNTH_SETUP, 24'h000020));
		settle(2);
		chk("comb_lock", 9'h000, comb);
		end_of_test();
	end
endmodule
